// file: verilog/fcfu_map.vh
// Register offsets, field positions, reset values and encodings of the compare flag unit
`ifndef FCFU_MAP_VH
`define FCFU_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define FCFU_A_CMD       8'h00
`define FCFU_A_STATW     8'h04
`define FCFU_A_TAGS      8'h08
`define FCFU_A_TOP0      8'h0c
`define FCFU_A_TOP1      8'h10
`define FCFU_A_TOP2      8'h14
`define FCFU_A_SRC0      8'h18
`define FCFU_A_SRC1      8'h1c
`define FCFU_A_SRC2      8'h20
`define FCFU_A_INTSRC    8'h24
`define FCFU_A_IFLAGS    8'h28
`define FCFU_A_AXCOPY    8'h2c
`define FCFU_A_FEATURE   8'h30
`define FCFU_A_IRQSTAT   8'h34
`define FCFU_A_IRQMASK   8'h38
`define FCFU_A_BUSY      8'h3c

// ****************************************************************
// Status word fields
// ****************************************************************
`define FCFU_SW_INVALID  0
`define FCFU_SW_CB0      8
`define FCFU_SW_CB1      9
`define FCFU_SW_CB2      10
`define FCFU_SW_TOP_LO   11
`define FCFU_SW_TOP_HI   13
`define FCFU_SW_CB3      14

// Integer flag positions inside the flags register
`define FCFU_IF_CARRY    0
`define FCFU_IF_PARITY   2
`define FCFU_IF_ZERO     6

// Interrupt status bits
`define FCFU_IRQ_DONE    0
`define FCFU_IRQ_INVALID 1
`define FCFU_IRQ_REFUSED 2

// ****************************************************************
// Reset values
// ****************************************************************
`define FCFU_RST_STATW   16'h0000
`define FCFU_RST_TAGS    8'hff
`define FCFU_RST_MASK    3'h0
`define FCFU_FEATURE_FLAGCMP 32'h0000_0001

// ****************************************************************
// Operation codes
// ****************************************************************
`define FCFU_OP_REG_CMP      4'h0
`define FCFU_OP_REG_CMP_POP  4'h1
`define FCFU_OP_INT_CMP      4'h2
`define FCFU_OP_INT_CMP_POP  4'h3
`define FCFU_OP_ZERO_TEST    4'h4
`define FCFU_OP_FLAG_CMP     4'h5
`define FCFU_OP_FLAG_CMP_POP 4'h6
`define FCFU_OP_UFLAG_CMP    4'h7
`define FCFU_OP_UFLAG_CMP_POP 4'h8
`define FCFU_OP_CLASSIFY     4'h9
`define FCFU_OP_SW_STORE     4'ha

// ****************************************************************
// Classify encodings {bit three, bit two, bit zero}
// ****************************************************************
`define FCFU_CLS_UNSUP   3'h0
`define FCFU_CLS_NAN     3'h1
`define FCFU_CLS_NORMAL  3'h2
`define FCFU_CLS_INF     3'h3
`define FCFU_CLS_ZERO    3'h4
`define FCFU_CLS_EMPTY   3'h5
`define FCFU_CLS_DENORM  3'h6

// Extended format constants
`define FCFU_EXP_ONES    15'h7fff
`define FCFU_EXP_BIAS    15'h3fff

`endif

// file: verilog/fcfu_cmp_core.v
// Combinational compare and classify core for double extended operands
`timescale 1ns/1ps
`default_nettype none
`include "fcfu_map.vh"

module fcfu_cmp_core (
  input  wire [79:0] a,
  input  wire [79:0] b,
  input  wire        a_empty,
  input  wire        quiet_ok,
  output reg         gt,
  output reg         lt,
  output reg         eq,
  output reg         unord,
  output reg         invalid,
  output reg  [2:0]  cls,
  output wire        sign
);

  // ****************************************************************
  // Operand decode
  // ****************************************************************
  // Class decode shared by both operands
  function [2:0] fcfu_class;
    input [79:0] v;
    begin
      if (v[78:64] == `FCFU_EXP_ONES)
        fcfu_class = (v[62:0] == 63'h0) ? `FCFU_CLS_INF : `FCFU_CLS_NAN;
      else if (v[78:64] == 15'h0)
        fcfu_class = (v[63:0] == 64'h0) ? `FCFU_CLS_ZERO : `FCFU_CLS_DENORM;
      else if (!v[63])
        fcfu_class = `FCFU_CLS_UNSUP; // Unnormals carry no valid value
      else
        fcfu_class = `FCFU_CLS_NORMAL;
    end
  endfunction

  wire [2:0] ca = fcfu_class(a);
  wire [2:0] cb = fcfu_class(b);
  wire       a_nan = (ca == `FCFU_CLS_NAN);
  wire       b_nan = (cb == `FCFU_CLS_NAN);
  // Signalling NaN has the top fraction bit clear
  wire       a_snan = a_nan && !a[62];
  wire       b_snan = b_nan && !b[62];
  wire       bad = a_empty || ca == `FCFU_CLS_UNSUP || cb == `FCFU_CLS_UNSUP;
  wire       mag_gt = a[78:0] > b[78:0];
  wire       mag_eq = a[78:0] == b[78:0];

  assign sign = a[79];

  // Ordering with zeros of either sign treated as equal
  always @* begin
    gt      = 1'b0;
    lt      = 1'b0;
    eq      = 1'b0;
    unord   = 1'b0;
    invalid = 1'b0;
    cls     = a_empty ? `FCFU_CLS_EMPTY : ca;
    if (bad || a_nan || b_nan) begin
      unord = 1'b1;
      // Quiet NaNs only fault on the ordinary compares
      invalid = bad || a_snan || b_snan || !quiet_ok;
    end else if (ca == `FCFU_CLS_ZERO && cb == `FCFU_CLS_ZERO) begin
      eq = 1'b1;
    end else if (a[79] != b[79]) begin
      gt = b[79];
      lt = a[79];
    end else if (mag_eq) begin
      eq = 1'b1;
    end else begin
      gt = mag_gt ^ a[79];
      lt = !(mag_gt ^ a[79]);
    end
  end

endmodule
`default_nettype wire

// file: verilog/fcfu_top.v
// APB-attached floating-point compare, classify and flag unit
//
// Overview of operation
// - An equal compare sets bit three and clears bits two and zero; unordered sets all three.
// - A greater compare clears condition bits three, two and zero.
// - A less compare sets bit zero and clears bits three and two.
// - Integer compares convert the 32-bit memory integer to extended format, then compare as usual.
// - The popping integer compare pops the stack once after recording the result.
// - The zero test compares the stack top against positive zero with the same encoding.
// - Flag compares do the same comparison but report in the zero, parity and carry flags.
// - Greater clears all three flags, less sets carry, equal sets zero, unordered sets all three.
// - Unordered flag compares raise no invalid exception for quiet NaN operands.
// - Popping flag compares of both kinds pop the stack once after the comparison.
// - Classify encodes empty, zero, denormal, normal, infinity, NaN or unsupported in the condition bits.
// - Classify sets condition bit one to the sign of the stack top.
// - A read-only feature bit reports that flag compares exist.
// - A status word store copies the status word to an AX copy that software tests with 0400H.
// - Other writes may change the condition bits, so the store takes a frozen snapshot.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "fcfu_map.vh"

module fcfu_top #(
  parameter [31:0] FEATURE_BITS = `FCFU_FEATURE_FLAGCMP
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq
);

  // ****************************************************************
  // Local definitions
  // ****************************************************************
  localparam [1:0] S_IDLE   = 2'd0;
  localparam [1:0] S_EXEC   = 2'd1;
  localparam [1:0] S_COMMIT = 2'd2;

  reg  [1:0]  state_r;
  reg  [3:0]  op_r;
  reg  [15:0] statw_r;
  reg  [7:0]  tags_r;
  reg  [79:0] top_r;
  reg  [79:0] src_r;
  reg  [31:0] int_r;
  reg  [79:0] opb_r;
  reg  [2:0]  iflags_r;
  reg  [15:0] ax_r;
  reg  [2:0]  irq_stat_r;
  reg  [2:0]  irq_mask_r;
  reg  [2:0]  irq_nxt;
  reg  [15:0] statw_nxt;
  reg  [7:0]  tags_nxt;

  // Operations that pop once their result is recorded
  function fcfu_pops;
    input [3:0] op;
    begin
      fcfu_pops = (op == `FCFU_OP_REG_CMP_POP) || (op == `FCFU_OP_INT_CMP_POP) ||
                  (op == `FCFU_OP_FLAG_CMP_POP) || (op == `FCFU_OP_UFLAG_CMP_POP);
    end
  endfunction

  // Operations that report in the integer flags
  function fcfu_to_flags;
    input [3:0] op;
    begin
      fcfu_to_flags = (op == `FCFU_OP_FLAG_CMP) || (op == `FCFU_OP_FLAG_CMP_POP) ||
                      (op == `FCFU_OP_UFLAG_CMP) || (op == `FCFU_OP_UFLAG_CMP_POP);
    end
  endfunction

  // Signed 32-bit integer to extended format; exact, no rounding needed
  function [79:0] fcfu_int_to_ext;
    input [31:0] v;
    reg   [31:0] m;
    reg   [4:0]  msb;
    reg   [63:0] s;
    integer      i;
    begin
      m = v[31] ? (~v + 32'h0000_0001) : v;
      msb = 5'h0;
      for (i = 0; i < 32; i = i + 1) begin
        if (m[i])
          msb = i[4:0];
      end
      s = {m, 32'h0000_0000} << (5'd31 - msb);
      if (v == 32'h0000_0000)
        fcfu_int_to_ext = 80'h0;
      else
        fcfu_int_to_ext = {v[31], `FCFU_EXP_BIAS + {10'h0, msb}, s};
    end
  endfunction

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire [7:0] addr     = paddr[7:0];
  wire       setup    = psel && !penable;
  // A refused transfer must not write, even where its low byte aliases a register
  wire       wr_take  = psel && penable && pready && pwrite && !pslverr;
  wire       hi_clear = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'b00);
  wire [2:0] top_idx  = statw_r[`FCFU_SW_TOP_HI:`FCFU_SW_TOP_LO];
  wire       top_empty = tags_r[top_idx];
  wire       cmd_wr   = wr_take && addr == `FCFU_A_CMD;
  wire       cmd_ok   = (pwdata[3:0] <= `FCFU_OP_SW_STORE) && state_r == S_IDLE;

  // Address map check used for the error answer
  function fcfu_mapped;
    input [7:0] a;
    begin
      fcfu_mapped = (a <= `FCFU_A_BUSY);
    end
  endfunction

  // Read mux; prepared in the setup cycle so prdata is a flop
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (addr == `FCFU_A_CMD)
      rd_mux = {28'h0, op_r};
    else if (addr == `FCFU_A_STATW)
      rd_mux = {16'h0, statw_r};
    else if (addr == `FCFU_A_TAGS)
      rd_mux = {24'h0, tags_r};
    else if (addr == `FCFU_A_TOP0)
      rd_mux = top_r[31:0];
    else if (addr == `FCFU_A_TOP1)
      rd_mux = top_r[63:32];
    else if (addr == `FCFU_A_TOP2)
      rd_mux = {16'h0, top_r[79:64]};
    else if (addr == `FCFU_A_SRC0)
      rd_mux = src_r[31:0];
    else if (addr == `FCFU_A_SRC1)
      rd_mux = src_r[63:32];
    else if (addr == `FCFU_A_SRC2)
      rd_mux = {16'h0, src_r[79:64]};
    else if (addr == `FCFU_A_INTSRC)
      rd_mux = int_r;
    else if (addr == `FCFU_A_IFLAGS)
      rd_mux = {25'h0, iflags_r[2], 3'h0, iflags_r[1], 1'b0, iflags_r[0]};
    else if (addr == `FCFU_A_AXCOPY)
      rd_mux = {16'h0, ax_r};
    else if (addr == `FCFU_A_FEATURE)
      rd_mux = FEATURE_BITS;
    else if (addr == `FCFU_A_IRQSTAT)
      rd_mux = {29'h0, irq_stat_r};
    else if (addr == `FCFU_A_IRQMASK)
      rd_mux = {29'h0, irq_mask_r};
    else if (addr == `FCFU_A_BUSY)
      rd_mux = {31'h0, state_r != S_IDLE};
  end

  // No wait states: answer in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !(hi_clear && fcfu_mapped(addr));
        prdata  <= (hi_clear && !pwrite) ? rd_mux : 32'h0000_0000;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Compare core
  // ****************************************************************
  wire       c_gt;
  wire       c_lt;
  wire       c_eq;
  wire       c_unord;
  wire       c_inv;
  wire [2:0] c_cls;
  wire       c_sign;
  wire       quiet_ok = (op_r == `FCFU_OP_UFLAG_CMP) || (op_r == `FCFU_OP_UFLAG_CMP_POP);

  fcfu_cmp_core u_core (
    .a        (top_r),
    .b        (opb_r),
    .a_empty  (top_empty),
    .quiet_ok (quiet_ok),
    .gt       (c_gt),
    .lt       (c_lt),
    .eq       (c_eq),
    .unord    (c_unord),
    .invalid  (c_inv),
    .cls      (c_cls),
    .sign     (c_sign)
  );

  // ****************************************************************
  // Operation sequencer
  // ****************************************************************
  // Second operand chosen in EXEC so the converter sits off the compare path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      op_r    <= 4'h0;
      opb_r   <= 80'h0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (cmd_wr && cmd_ok) begin
            op_r    <= pwdata[3:0];
            state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (op_r == `FCFU_OP_INT_CMP || op_r == `FCFU_OP_INT_CMP_POP)
            opb_r <= fcfu_int_to_ext(int_r);
          else if (op_r == `FCFU_OP_ZERO_TEST)
            opb_r <= 80'h0; // Positive zero
          else
            opb_r <= src_r;
          state_r <= S_COMMIT;
        end
        S_COMMIT: state_r <= S_IDLE;
        default:  state_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Status word, tags and results
  // ****************************************************************
  wire commit  = (state_r == S_COMMIT);
  wire is_cls  = (op_r == `FCFU_OP_CLASSIFY);
  wire is_sws  = (op_r == `FCFU_OP_SW_STORE);
  wire do_cmp  = commit && !is_cls && !is_sws;

  // Next status word; the commit wins over a same-cycle software write
  always @* begin
    statw_nxt = statw_r;
    tags_nxt  = tags_r;
    if (wr_take && addr == `FCFU_A_STATW)
      statw_nxt = pwdata[15:0]; // Direct load also moves the condition bits
    if (wr_take && addr == `FCFU_A_TAGS)
      tags_nxt = pwdata[7:0];
    if (commit && is_cls) begin
      statw_nxt[`FCFU_SW_CB3] = c_cls[2];
      statw_nxt[`FCFU_SW_CB2] = c_cls[1];
      statw_nxt[`FCFU_SW_CB0] = c_cls[0];
      statw_nxt[`FCFU_SW_CB1] = c_sign;
    end else if (do_cmp) begin
      if (!fcfu_to_flags(op_r)) begin
        // Equal 100, unordered 111, greater 000, less 001
        statw_nxt[`FCFU_SW_CB3] = c_eq || c_unord;
        statw_nxt[`FCFU_SW_CB2] = c_unord;
        statw_nxt[`FCFU_SW_CB0] = c_lt || c_unord;
        statw_nxt[`FCFU_SW_CB1] = 1'b0;
      end
      if (c_inv)
        statw_nxt[`FCFU_SW_INVALID] = 1'b1;
      if (fcfu_pops(op_r)) begin
        // Pop after the result is in place
        tags_nxt[top_idx] = 1'b1;
        statw_nxt[`FCFU_SW_TOP_HI:`FCFU_SW_TOP_LO] = top_idx + 3'd1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      statw_r  <= `FCFU_RST_STATW;
      tags_r   <= `FCFU_RST_TAGS;
      iflags_r <= 3'h0;
      ax_r     <= 16'h0000;
    end else begin
      statw_r <= statw_nxt;
      tags_r  <= tags_nxt;
      if (do_cmp && fcfu_to_flags(op_r))
        iflags_r <= {c_eq || c_unord, c_unord, c_lt || c_unord};
      if (commit && is_sws)
        ax_r <= statw_r; // Snapshot, later changes do not reach it
    end
  end

  // ****************************************************************
  // Operand registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_r <= 80'h0;
      src_r <= 80'h0;
      int_r <= 32'h0000_0000;
    end else if (wr_take) begin
      if (addr == `FCFU_A_TOP0)
        top_r[31:0] <= pwdata;
      else if (addr == `FCFU_A_TOP1)
        top_r[63:32] <= pwdata;
      else if (addr == `FCFU_A_TOP2)
        top_r[79:64] <= pwdata[15:0];
      else if (addr == `FCFU_A_SRC0)
        src_r[31:0] <= pwdata;
      else if (addr == `FCFU_A_SRC1)
        src_r[63:32] <= pwdata;
      else if (addr == `FCFU_A_SRC2)
        src_r[79:64] <= pwdata[15:0];
      else if (addr == `FCFU_A_INTSRC)
        int_r <= pwdata;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // Hardware set beats a write-one clear in the same cycle
  always @* begin
    irq_nxt = irq_stat_r;
    if (wr_take && addr == `FCFU_A_IRQSTAT)
      irq_nxt = irq_stat_r & ~pwdata[2:0];
    if (commit)
      irq_nxt[`FCFU_IRQ_DONE] = 1'b1;
    if (do_cmp && c_inv)
      irq_nxt[`FCFU_IRQ_INVALID] = 1'b1;
    if (cmd_wr && !cmd_ok)
      irq_nxt[`FCFU_IRQ_REFUSED] = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= `FCFU_RST_MASK;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= irq_nxt;
      if (wr_take && addr == `FCFU_A_IRQMASK)
        irq_mask_r <= pwdata[2:0];
      irq <= |(irq_nxt & irq_mask_r); // Changes on the same edge as the status, not one edge later as a flop of irq_stat_r would
    end
  end

endmodule
`default_nettype wire

// file: verif/fcfu_monitor.sv
// Bus and feature checker bound to the compare flag unit top
`timescale 1ns/1ps
`default_nettype none
`include "fcfu_map.vh"

module fcfu_monitor #(
  parameter [31:0] FEATURE_BITS = `FCFU_FEATURE_FLAGCMP
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // Bus phases seen at a setup edge
  // ****************************************************************
  sequence s_setup;
    psel && !penable;
  endsequence

  // Feature word read: software checks this before using flag compares
  sequence s_rd_feature;
    psel && !penable && !pwrite && paddr == {24'h00_0000, `FCFU_A_FEATURE};
  endsequence

  // Only bits 7:2 decode, so any other address bit must be refused
  sequence s_bad_addr;
    psel && !penable && (paddr[31:8] != 24'h00_0000 || paddr[1:0] != 2'h0);
  endsequence

  sequence s_wr_setup;
    psel && !penable && pwrite;
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  chk_ready_has_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without a setup");
  chk_feature_value: assert property (s_rd_feature |=> prdata == FEATURE_BITS)
    else $error("feature word wrong");
  chk_feature_no_err: assert property (s_rd_feature ##1 pready |-> !pslverr)
    else $error("feature read refused");
  chk_bad_addr_err: assert property (s_bad_addr |=> pready && pslverr)
    else $error("bad address not refused");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error outside access cycle");
  chk_write_no_data: assert property (s_wr_setup |=> prdata == 32'h0000_0000)
    else $error("read data driven on write");

  cover property (s_bad_addr ##1 pslverr);
endmodule

bind fcfu_top fcfu_monitor #(.FEATURE_BITS(FEATURE_BITS)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// file: verif/fcfu_top_tb_top.sv
// Self-checking register level testbench of the compare flag unit
`timescale 1ns/1ps
`default_nettype none
`include "fcfu_map.vh"

module fcfu_top_tb_top;
  localparam logic [79:0] V_ONE  = 80'h3fff_8000_0000_0000_0000;
  localparam logic [79:0] V_TWO  = 80'h4000_8000_0000_0000_0000;
  localparam logic [79:0] V_NEG  = 80'hbfff_8000_0000_0000_0000;
  localparam logic [79:0] V_ZERO = 80'h0000_0000_0000_0000_0000;
  localparam logic [79:0] V_INF  = 80'h7fff_8000_0000_0000_0000;
  localparam logic [79:0] V_QNAN = 80'h7fff_c000_0000_0000_0000;
  localparam logic [79:0] V_DEN  = 80'h0000_0000_0000_0000_0001;
  localparam logic [79:0] V_UNS  = 80'h3fff_0000_0000_0000_0000;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         irq;
  int          miscompares;
  int          num_checks;
  logic [31:0] q;
  logic        e;
  // Ops alternate plain and popping, then ordinary and quiet flag forms
  logic [3:0]  ops [6] = '{`FCFU_OP_REG_CMP, `FCFU_OP_REG_CMP_POP, `FCFU_OP_FLAG_CMP,
                           `FCFU_OP_FLAG_CMP_POP, `FCFU_OP_UFLAG_CMP, `FCFU_OP_UFLAG_CMP_POP};
  logic [79:0] ta [4] = '{V_TWO, V_ONE, V_ONE, V_ONE};
  logic [79:0] sa [4] = '{V_ONE, V_TWO, V_ONE, V_QNAN};
  logic [15:0] cx [4] = '{16'h0000, 16'h0100, 16'h4000, 16'h4500};
  logic [7:0]  fx [4] = '{8'h00, 8'h01, 8'h40, 8'h45};
  logic [15:0] bm [4] = '{16'h4500, 16'h0100, 16'h4000, 16'h0400};
  logic [79:0] kv [7] = '{V_ZERO, V_NEG, V_INF, V_QNAN, V_DEN, V_UNS, V_ZERO};
  logic [15:0] kx [7] = '{16'h4000, 16'h0600, 16'h0500, 16'h0100, 16'h4400, 16'h0000, 16'h4100};
  logic [79:0] zt [3] = '{V_NEG, V_ZERO, V_ONE};
  logic [15:0] zx [3] = '{16'h0100, 16'h4000, 16'h0000};

  fcfu_top #(.FEATURE_BITS(`FCFU_FEATURE_FLAGCMP)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  // ****************************************************************
  // Clock and helpers
  // ****************************************************************
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; bb keeps select up so the next setup follows at once
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic bb);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    penable <= 1'b0;
    if (!bb) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask

  task rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000, 1'b0);
  endtask

  // Operands travel as three words, sign and exponent in the last
  task set80(input logic [7:0] a, input logic [79:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, v[63:32]);
    wr(a + 8'h08, {16'h0000, v[79:64]});
  endtask

  // Clearing the status word also puts the stack top back at slot 0
  task prep(input logic [79:0] t, input logic [79:0] s, input logic [7:0] tg);
    wr(`FCFU_A_STATW, 32'h0000_0000);
    wr(`FCFU_A_TAGS, {24'h00_0000, tg});
    set80(`FCFU_A_TOP0, t);
    set80(`FCFU_A_SRC0, s);
  endtask

  task run(input logic [3:0] op);
    int n;
    wr(`FCFU_A_CMD, {28'h000_0000, op});
    n = 0;
    do begin
      rd(`FCFU_A_BUSY);
      n++;
    end while (q[0] !== 1'b0 && n < 50);
    if (q[0] !== 1'b0) miscompares++;
  endtask

  task results;
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog: the sequence needs roughly 1500 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    results;
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    int o;
    int i;
    int k;
    logic [31:0] ex;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    num_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FCFU_A_STATW);
    chk(q, 32'h0000_0000);
    rd(`FCFU_A_TAGS);
    chk(q, 32'h0000_00ff);
    rd(`FCFU_A_FEATURE);
    chk(q, `FCFU_FEATURE_FLAGCMP);
    rd(8'h42);
    chk(e, 1'b1);
    wr(`FCFU_A_IRQMASK, 32'h0000_0007);
    // Each register and flag compare form against greater, less, equal and quiet NaN
    for (o = 0; o < 6; o++) begin
      for (i = 0; i < 4; i++) begin
        prep(ta[i], sa[i], 8'hfe);
        run(ops[o]);
        ex = (o >= 2) ? 32'h0000_0000 : {16'h0000, cx[i]};
        if (o % 2 == 1) ex = ex | 32'h0000_0800;
        if (i == 3 && o < 4) ex = ex | 32'h0000_0001;
        rd(`FCFU_A_STATW);
        chk(q & 32'h0000_7f01, ex);
        rd(`FCFU_A_TAGS);
        chk(q, (o % 2 == 1) ? 32'h0000_00ff : 32'h0000_00fe);
        if (o >= 2) begin
          rd(`FCFU_A_IFLAGS);
          chk(q & 32'h0000_0045, {24'h00_0000, fx[i]});
        end
        if (o == 0) begin
          run(`FCFU_OP_SW_STORE);
          rd(`FCFU_A_AXCOPY);
          chk(q & 32'h0000_4700, {16'h0000, cx[i]});
          chk({31'h0000_0000, (q[15:0] & bm[i]) != 16'h0000}, {31'h0000_0000, i != 0});
        end
      end
    end
    // A later status word change must leave the stored copy alone
    wr(`FCFU_A_STATW, 32'h0000_0100);
    rd(`FCFU_A_AXCOPY);
    chk(q & 32'h0000_4700, 32'h0000_4500);
    // Memory integer compares, the second one popping
    prep(V_TWO, V_ZERO, 8'hfe);
    wr(`FCFU_A_INTSRC, 32'h0000_0002);
    run(`FCFU_OP_INT_CMP);
    rd(`FCFU_A_STATW);
    chk(q & 32'h0000_7f00, 32'h0000_4000);
    wr(`FCFU_A_INTSRC, 32'hffff_fffd);
    run(`FCFU_OP_INT_CMP_POP);
    rd(`FCFU_A_STATW);
    chk(q & 32'h0000_7f00, 32'h0000_0800);
    rd(`FCFU_A_TAGS);
    chk(q, 32'h0000_00ff);
    // Zero test ignores the loaded source
    for (k = 0; k < 3; k++) begin
      prep(zt[k], V_NEG, 8'hfe);
      run(`FCFU_OP_ZERO_TEST);
      rd(`FCFU_A_STATW);
      chk(q & 32'h0000_4700, {16'h0000, zx[k]});
    end
    // Classify each kind of value, the last one on an empty slot
    for (k = 0; k < 7; k++) begin
      prep(kv[k], V_ZERO, (k == 6) ? 8'hff : 8'hfe);
      run(`FCFU_OP_CLASSIFY);
      rd(`FCFU_A_STATW);
      chk(q & 32'h0000_4700, {16'h0000, kx[k]});
    end
    // Ordinary compares of a quiet NaN left the invalid event pending
    rd(`FCFU_A_IRQSTAT);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    // Interrupt: raise, mask, refuse, clear
    prep(V_ONE, V_ONE, 8'hfe);
    wr(`FCFU_A_IRQSTAT, 32'h0000_0007);
    rd(`FCFU_A_IRQSTAT);
    chk(q, 32'h0000_0000);
    chk(irq, 1'b0);
    run(`FCFU_OP_REG_CMP);
    chk(irq, 1'b1);
    wr(`FCFU_A_IRQMASK, 32'h0000_0006);
    rd(`FCFU_A_IRQSTAT);
    chk(q, 32'h0000_0001);
    chk(irq, 1'b0);
    wr(`FCFU_A_CMD, 32'h0000_000b);
    rd(`FCFU_A_IRQSTAT);
    chk(q, 32'h0000_0005);
    chk(irq, 1'b1);
    wr(`FCFU_A_IRQSTAT, 32'h0000_0005);
    rd(`FCFU_A_IRQSTAT);
    chk(q, 32'h0000_0000);
    chk(irq, 1'b0);
    // A command too soon after another is refused
    xfer(1'b1, `FCFU_A_CMD, 32'h0000_0000, 1'b1);
    wr(`FCFU_A_CMD, 32'h0000_0000);
    rd(`FCFU_A_BUSY);
    rd(`FCFU_A_IRQSTAT);
    chk(q & 32'h0000_0004, 32'h0000_0004);
    results;
  end
endmodule
`default_nettype wire
